/* File: hw/fpl_logger.sv */
`timescale 1ns/1ps
`include "fpl_params.svh"
// Operation
// - Outside brownout mode a new value above the logged peak starts the shared 30-second collection timer if it is not running.
// - At interval end only the largest collected value goes to flash.
// - Voltage, current and temperature peaks are kept apart for every rail.
// - Fault entries hold rail, fault type, time since reset, last rail voltage.
// - The host can read back stored fault entries.
// - A reset count lives in flash and the host can clear it.
// - In brownout mode clock, peaks and faults reach flash only at power-down.
// - Brownout mode keeps the run-time clock over resets; otherwise it restarts at zero.
// - The host may write the run-time clock and converts its units itself.
// - Supply falling below 2.9 V is a brownout event that starts the save.
// - In brownout mode log data stays in SRAM and no flash write happens before a brownout event.
// - On a brownout event the whole SRAM log is copied to flash.
// - Brownout mode is off unless the start-up flash value or the host configuration enables it.
module fpl_logger
    import fpl_pkg::*;
#(
    parameter logic [31:0] PEAK_CYCLES     = 32'(64'(`FPL_PEAK_TIME_S) * 64'(`FPL_CLK_HZ)),
    parameter logic [31:0] RTC_TICK_CYCLES = 32'(64'(`FPL_RTC_TICK_US) * 64'(`FPL_CLK_HZ) / 64'd1000000)
) (
    // Clock and reset.
    input  wire logic    sys_clk,
    input  wire logic    rst,
    // Monitor events.
    input  fpl_meas_t     meas,
    input  fpl_fault_in_t fault_in,
    input  wire logic    supply_low,
    // Values restored from flash at start-up.
    input  fpl_nv_t       nv,
    // Host command port.
    input  fpl_host_req_t host_req,
    output fpl_host_rsp_t host_rsp,
    // Flash write port.
    output fpl_flash_wr_t flash_wr,
    input  wire logic    flash_ready,
    // Mode status.
    output logic          brownout_mode
);

    fpl_state_t q;
    fpl_state_t next_q;
    logic [5:0] meas_idx;
    logic       tick;
    logic       expire;
    logic       brown_evt;
    logic [63:0] slot_data;

    // Index of the peak record for one rail and quantity.
    function automatic logic [5:0] fpl_peak_idx(input logic [3:0] rail, input logic [1:0] qty);
        fpl_peak_idx = 6'(rail) * 6'(`FPL_NUM_QTY) + 6'(qty);
    endfunction

    // Lowest pending flash slot.
    function automatic logic [5:0] fpl_first(input logic [`FPL_NUM_SLOTS-1:0] p);
        fpl_first = 6'h0;
        for (int i = `FPL_NUM_SLOTS - 1; i >= 0; i--) begin
            if (p[i]) begin
                fpl_first = 6'(i);
            end
        end
    endfunction

    assign meas_idx  = fpl_peak_idx(meas.rail, meas.qty);
    assign tick      = (q.rtc_div == RTC_TICK_CYCLES - 32'h1);
    assign expire    = q.peak_run && (q.peak_timer == PEAK_CYCLES - 32'h1);
    assign brown_evt = supply_low && !q.supply_low_q && q.brownout_en;

    // Data of the slot that the writer sends next.
    always_comb begin
        slot_data = 64'h0;
        if (fpl_first(q.pending) == 6'(`FPL_SLOT_RESETS)) begin
            slot_data = 64'(q.resets);
        end
        if (fpl_first(q.pending) == 6'(`FPL_SLOT_RTC)) begin
            slot_data = 64'(q.rtc);
        end
        for (int i = 0; i < `FPL_NUM_PEAKS; i++) begin
            if (fpl_first(q.pending) == 6'(`FPL_SLOT_PEAK0 + i)) begin
                slot_data = 64'(q.logged[i]);
            end
        end
        for (int i = 0; i < `FPL_NUM_FAULTS; i++) begin
            if (fpl_first(q.pending) == 6'(`FPL_SLOT_FAULT0 + i)) begin
                slot_data = 64'(q.faults[i]);
            end
        end
    end

    // Next state of the whole logger.
    always_comb begin
        next_q = q;
        next_q.host_rsp.valid = 1'b0;
        next_q.supply_low_q = supply_low;
        // Flash writer; its clear of a pending bit comes before any new set.
        unique case (q.st)
            FPL_WR_BOOT: begin
                next_q.resets      = nv.reset_count + 32'h1;
                next_q.brownout_en = nv.brownout_en;
                next_q.rtc         = nv.brownout_en ? nv.rtc : 32'h0;
                next_q.pending[`FPL_SLOT_RESETS] = !nv.brownout_en;
                next_q.st = FPL_WR_IDLE;
            end
            FPL_WR_IDLE: begin
                if ((q.pending != '0) && (!q.brownout_en || q.saving)) begin
                    next_q.flash_wr.valid = 1'b1;
                    next_q.flash_wr.slot  = fpl_first(q.pending);
                    next_q.flash_wr.data  = slot_data;
                    next_q.st = FPL_WR_SEND;
                end
            end
            FPL_WR_SEND: begin
                if (flash_ready) begin
                    next_q.flash_wr.valid = 1'b0;
                    next_q.pending[q.flash_wr.slot] = 1'b0;
                    next_q.st = FPL_WR_IDLE;
                end
            end
        endcase
        if (q.st != FPL_WR_BOOT) begin
            // Run-time clock and time since reset advance on each tick.
            next_q.rtc_div = tick ? 32'h0 : q.rtc_div + 32'h1;
            if (tick) begin
                next_q.rtc    = q.rtc + 32'h1;
                next_q.uptime = q.uptime + 32'h1;
            end
            // End of a collection interval moves the largest values on.
            if (q.peak_run) begin
                next_q.peak_timer = q.peak_timer + 32'h1;
            end
            if (expire) begin
                next_q.peak_run   = 1'b0;
                next_q.peak_timer = 32'h0;
                next_q.touched    = '0;
                for (int i = 0; i < `FPL_NUM_PEAKS; i++) begin
                    if (q.touched[i]) begin
                        next_q.logged[i] = q.work[i];
                        next_q.pending[`FPL_SLOT_PEAK0 + i] = !q.brownout_en;
                    end
                end
            end
            // Measurements update the last voltage and the peak records.
            if (meas.valid && (meas.rail < 4'(`FPL_NUM_RAILS)) && (meas.qty < 2'(`FPL_NUM_QTY))) begin
                if (meas.qty == `FPL_QTY_VOLT) begin
                    next_q.last_v[meas.rail] = meas.value;
                end
                if (meas.value > next_q.logged[meas_idx]) begin
                    if (q.brownout_en) begin
                        next_q.logged[meas_idx] = meas.value;
                    end else begin
                        if (!next_q.touched[meas_idx] || (meas.value > q.work[meas_idx])) begin
                            next_q.work[meas_idx] = meas.value;
                        end
                        next_q.touched[meas_idx] = 1'b1;
                        if (!next_q.peak_run) begin
                            next_q.peak_run   = 1'b1;
                            next_q.peak_timer = 32'h0;
                        end
                    end
                end
            end
            // Faults go into a ring of entries.
            if (fault_in.valid && (fault_in.rail < 4'(`FPL_NUM_RAILS))) begin
                next_q.faults[q.fault_wr] = '{fault_in.rail, fault_in.ftype, q.uptime,
                                              q.last_v[fault_in.rail]};
                next_q.fault_wr = (q.fault_wr == 4'(`FPL_NUM_FAULTS - 1)) ? 4'h0 : q.fault_wr + 4'h1;
                if (q.fault_cnt != 4'(`FPL_NUM_FAULTS)) begin
                    next_q.fault_cnt = q.fault_cnt + 4'h1;
                end
                next_q.pending[6'(`FPL_SLOT_FAULT0) + 6'(q.fault_wr)] = !q.brownout_en;
            end
            // Host commands answer one cycle later.
            if (host_req.valid) begin
                next_q.host_rsp.valid = 1'b1;
                next_q.host_rsp.data  = 64'h0;
                unique case (host_req.op)
                    FPL_OP_NOP: begin
                    end
                    FPL_OP_READ_PEAK: begin
                        if (host_req.index < 6'(`FPL_NUM_PEAKS)) begin
                            next_q.host_rsp.data = 64'(q.logged[host_req.index]);
                        end
                    end
                    FPL_OP_READ_FAULT: begin
                        if (host_req.index < 6'(q.fault_cnt)) begin
                            next_q.host_rsp.data = 64'(q.faults[host_req.index]);
                        end
                    end
                    FPL_OP_READ_RESETS: begin
                        next_q.host_rsp.data = 64'(q.resets);
                    end
                    FPL_OP_CLEAR_RESETS: begin
                        next_q.resets = 32'h0;
                        next_q.pending[`FPL_SLOT_RESETS] = !q.brownout_en;
                    end
                    FPL_OP_READ_RTC: begin
                        next_q.host_rsp.data = 64'(q.rtc);
                    end
                    FPL_OP_WRITE_RTC: begin
                        next_q.rtc = host_req.data;
                    end
                    FPL_OP_WRITE_MISC: begin
                        next_q.brownout_en = host_req.data[0];
                    end
                endcase
            end
            // A brownout marks the entire log for copying to flash.
            if (brown_evt) begin
                next_q.saving  = 1'b1;
                next_q.pending = '1;
            end
        end
    end

    // State register; reset turns brownout mode off until the start-up cycle loads nv.brownout_en.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign host_rsp      = q.host_rsp;
    assign flash_wr      = q.flash_wr;
    assign brownout_mode = q.brownout_en;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_peak_rise;
        meas.valid && (meas.rail < 4'(`FPL_NUM_RAILS)) && (meas.qty < 2'(`FPL_NUM_QTY)) && !q.brownout_en
            && !q.peak_run && (q.st != FPL_WR_BOOT) && (meas.value > q.logged[meas_idx]);
    endsequence
    sequence s_expire_touched;
        expire && !q.brownout_en && (q.touched != '0) && (q.st != FPL_WR_BOOT);
    endsequence

    a_peak_timer_start: assert property (s_peak_rise |=> q.peak_run && (q.peak_timer == 32'h0))
        else $error("Peak timer did not start.");
    a_peak_expiry: assert property (s_expire_touched |=> (q.peak_timer == 32'h0) && (q.pending[`FPL_SLOT_PEAK0 +: `FPL_NUM_PEAKS] != '0))
        else $error("Peak interval end queued no flash write.");
    a_peak_hold: assert property (!q.brownout_en && !expire |=> $stable(q.logged))
        else $error("Logged peak changed inside an interval.");
    a_fault_store: assert property (fault_in.valid && (fault_in.rail < 4'(`FPL_NUM_RAILS)) && (q.st != FPL_WR_BOOT)
        |=> q.faults[$past(q.fault_wr)].rail == $past(fault_in.rail))
        else $error("Fault entry not stored.");
    a_host_answer: assert property (host_req.valid && (q.st != FPL_WR_BOOT) |=> q.host_rsp.valid ##1 !q.host_rsp.valid || $past(host_req.valid))
        else $error("Host command not answered.");
    a_resets_clear: assert property (host_req.valid && (host_req.op == FPL_OP_CLEAR_RESETS) && (q.st != FPL_WR_BOOT) |=> q.resets == 32'h0)
        else $error("Reset count not cleared.");
    a_brownout_quiet: assert property (q.brownout_en && !q.saving && (q.st == FPL_WR_IDLE) |=> !q.flash_wr.valid)
        else $error("Flash write in brownout mode before power-down.");
    a_brownout_save: assert property (brown_evt && (q.st != FPL_WR_BOOT) |=> q.saving && (&q.pending))
        else $error("Brownout did not mark whole log for saving.");
    a_rtc_boot: assert property ((q.st == FPL_WR_BOOT) && !nv.brownout_en |=> q.rtc == 32'h0)
        else $error("Run-time clock not restarted at zero.");
    a_rtc_write: assert property (host_req.valid && (host_req.op == FPL_OP_WRITE_RTC) && (q.st != FPL_WR_BOOT)
        |=> q.rtc == $past(host_req.data))
        else $error("Run-time clock write lost.");
    a_rtc_tick: assert property (tick && (q.st != FPL_WR_BOOT) && !(host_req.valid && (host_req.op == FPL_OP_WRITE_RTC))
        |=> q.rtc == $past(q.rtc) + 32'h1)
        else $error("Run-time clock missed a tick.");
    a_misc_write: assert property (host_req.valid && (host_req.op == FPL_OP_WRITE_MISC) && (q.st != FPL_WR_BOOT)
        |=> brownout_mode == $past(host_req.data[0]))
        else $error("Brownout enable not taken.");

endmodule

/* File: hw/fpl_params.svh */
`ifndef FPL_PARAMS_SVH
`define FPL_PARAMS_SVH

// Sizes of the log storage.
`define FPL_NUM_RAILS    12
`define FPL_NUM_QTY      3
`define FPL_NUM_PEAKS    36
`define FPL_NUM_FAULTS   10
`define FPL_NUM_SLOTS    48

// Quantity codes of a measurement.
`define FPL_QTY_VOLT     2'h0
`define FPL_QTY_CURR     2'h1
`define FPL_QTY_TEMP     2'h2

// Flash slot map: reset count, run-time clock, peaks, fault entries.
`define FPL_SLOT_RESETS  0
`define FPL_SLOT_RTC     1
`define FPL_SLOT_PEAK0   2
`define FPL_SLOT_FAULT0  38

// Timing.
`define FPL_CLK_HZ       100000000
`define FPL_PEAK_TIME_S  30
`define FPL_RTC_TICK_US  1000

`endif

/* File: hw/fpl_pkg.sv */
package fpl_pkg;
`include "fpl_params.svh"

    // Host command codes.
    typedef enum logic [2:0] {
        FPL_OP_NOP, FPL_OP_READ_PEAK, FPL_OP_READ_FAULT, FPL_OP_READ_RESETS,
        FPL_OP_CLEAR_RESETS, FPL_OP_READ_RTC, FPL_OP_WRITE_RTC, FPL_OP_WRITE_MISC
    } fpl_op_t;

    // States of the flash writer.
    typedef enum logic [1:0] {FPL_WR_BOOT, FPL_WR_IDLE, FPL_WR_SEND} fpl_wr_state_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  rail;
        logic [1:0]  qty;
        logic [11:0] value;
    } fpl_meas_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] rail;
        logic [3:0] ftype;
    } fpl_fault_in_t;

    typedef struct packed {
        logic [3:0]  rail;
        logic [3:0]  ftype;
        logic [31:0] time_ticks;
        logic [11:0] volts;
    } fpl_fault_t;

    typedef struct packed {
        logic        valid;
        fpl_op_t     op;
        logic [5:0]  index;
        logic [31:0] data;
    } fpl_host_req_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] data;
    } fpl_host_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [5:0]  slot;
        logic [63:0] data;
    } fpl_flash_wr_t;

    typedef struct packed {
        logic [31:0] reset_count;
        logic [31:0] rtc;
        logic        brownout_en;
    } fpl_nv_t;

    typedef struct packed {
        fpl_wr_state_t                              st;
        logic                                       brownout_en;
        logic                                       saving;
        logic                                       supply_low_q;
        logic [31:0]                                resets;
        logic [31:0]                                rtc;
        logic [31:0]                                uptime;
        logic [31:0]                                rtc_div;
        logic [31:0]                                peak_timer;
        logic                                       peak_run;
        logic [`FPL_NUM_PEAKS-1:0][11:0]            logged;
        logic [`FPL_NUM_PEAKS-1:0][11:0]            work;
        logic [`FPL_NUM_PEAKS-1:0]                  touched;
        logic [`FPL_NUM_RAILS-1:0][11:0]            last_v;
        fpl_fault_t [`FPL_NUM_FAULTS-1:0]           faults;
        logic [3:0]                                 fault_wr;
        logic [3:0]                                 fault_cnt;
        logic [`FPL_NUM_SLOTS-1:0]                  pending;
        fpl_host_rsp_t                              host_rsp;
        fpl_flash_wr_t                              flash_wr;
    } fpl_state_t;

endpackage

/* File: tb/fpl_flash_model.sv */
`timescale 1ns/1ps
`include "fpl_params.svh"
module fpl_flash_model
    import fpl_pkg::*;
(
    // Clock and reset.
    input  wire logic     sys_clk,
    input  wire logic     rst,
    // Write port of the logger.
    input  fpl_flash_wr_t flash_wr,
    output logic          flash_ready,
    // Latency select.
    input  wire logic     slow
);
    logic [63:0] mem [`FPL_NUM_SLOTS];
    int          writes = 0;
    logic [2:0]  wait_cnt;

    // Stores one word per write, answering after one wait cycle, or after four when slow.
    // The array and count survive reset, as flash contents would.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flash_ready <= 1'b0;
            wait_cnt    <= 3'h0;
        end else if (flash_wr.valid && flash_ready) begin
            mem[flash_wr.slot] <= flash_wr.data;
            writes             <= writes + 1;
            flash_ready        <= 1'b0;
            wait_cnt           <= 3'h0;
        end else if (flash_wr.valid) begin
            wait_cnt    <= wait_cnt + 3'h1;
            flash_ready <= !slow || (wait_cnt == 3'h3);
        end
    end
endmodule

/* File: tb/tb_fpl_logger.sv */
`timescale 1ns/1ps
`include "fpl_params.svh"
module tb_fpl_logger
    import fpl_pkg::*;
;
    logic          sys_clk;
    logic          rst;
    logic          supply_low;
    logic          flash_ready;
    logic          slow;
    logic          brownout_mode;
    fpl_meas_t     meas;
    fpl_fault_in_t fault_in;
    fpl_nv_t       nv;
    fpl_host_req_t host_req;
    fpl_host_rsp_t host_rsp;
    fpl_flash_wr_t flash_wr;
    int            compares;
    int            miscompares;
    int            n;
    logic [63:0]   rsp;
    logic [63:0]   r2;

    // Short counts keep the run brief.
    fpl_logger #(.PEAK_CYCLES(32'h32), .RTC_TICK_CYCLES(32'hA)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .meas(meas), .fault_in(fault_in),
        .supply_low(supply_low), .nv(nv), .host_req(host_req), .host_rsp(host_rsp),
        .flash_wr(flash_wr), .flash_ready(flash_ready), .brownout_mode(brownout_mode));

    fpl_flash_model i_flash (
        .sys_clk(sys_clk), .rst(rst), .flash_wr(flash_wr),
        .flash_ready(flash_ready), .slow(slow));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short.
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds reset three cycles, then waits out the start-up cycle.
    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // One host command; the answer is taken one cycle after the request.
    task automatic host(input fpl_op_t op, input logic [5:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        host_req <= '{valid: 1'b1, op: op, index: idx, data: d};
        @(posedge sys_clk);
        host_req.valid <= 1'b0;
        #1;
        chk(64'(host_rsp.valid), 64'h1);
        rsp = host_rsp.data;
    endtask

    task automatic meas_pulse(input logic [3:0] rail, input logic [1:0] qty, input logic [11:0] v);
        @(posedge sys_clk);
        meas <= '{1'b1, rail, qty, v};
        @(posedge sys_clk);
        meas.valid <= 1'b0;
    endtask

    task automatic fault_pulse(input logic [3:0] rail, input logic [3:0] ftype);
        @(posedge sys_clk);
        fault_in <= '{1'b1, rail, ftype};
        @(posedge sys_clk);
        fault_in.valid <= 1'b0;
    endtask

    // Start-up with brownout off: count bumped and saved, clock restarted.
    task automatic test_boot();
        host(FPL_OP_READ_RESETS, 6'h0, 32'h0);
        chk(rsp, 64'h6);
        chk(64'(brownout_mode), 64'h0);
        host(FPL_OP_READ_RTC, 6'h0, 32'h0);
        chk(64'(rsp < 64'h64), 64'h1);
        repeat (20) @(posedge sys_clk);
        chk(i_flash.mem[`FPL_SLOT_RESETS], 64'h6);
        host(FPL_OP_CLEAR_RESETS, 6'h0, 32'h0);
        host(FPL_OP_READ_RESETS, 6'h0, 32'h0);
        chk(rsp, 64'h0);
        host(FPL_OP_NOP, 6'h0, 32'h0);
        chk(rsp, 64'h0);
        repeat (5) @(posedge sys_clk);
        chk(i_flash.mem[`FPL_SLOT_RESETS], 64'h0);
    endtask

    // Host sets the clock; two reads 100 cycles apart differ by ten ticks.
    task automatic test_rtc();
        host(FPL_OP_WRITE_RTC, 6'h0, 32'h3E8);
        host(FPL_OP_READ_RTC, 6'h0, 32'h0);
        chk(64'(rsp == 64'h3E8 || rsp == 64'h3E9), 64'h1);
        r2 = rsp;
        repeat (98) @(posedge sys_clk);
        host(FPL_OP_READ_RTC, 6'h0, 32'h0);
        chk(rsp - r2, 64'hA);
    endtask

    // Rising samples wait for the interval, then only the maximum is saved.
    task automatic test_peaks();
        n = i_flash.writes;
        meas_pulse(4'h2, `FPL_QTY_VOLT, 12'h100);
        meas_pulse(4'h2, `FPL_QTY_VOLT, 12'h180);
        meas_pulse(4'h2, `FPL_QTY_CURR, 12'h050);
        meas_pulse(4'h2, `FPL_QTY_VOLT, 12'h120);
        host(FPL_OP_READ_PEAK, 6'h6, 32'h0);
        chk(rsp, 64'h0);
        chk(64'(i_flash.writes - n), 64'h0);
        repeat (70) @(posedge sys_clk);
        chk(i_flash.mem[`FPL_SLOT_PEAK0 + 6], 64'h180);
        chk(i_flash.mem[`FPL_SLOT_PEAK0 + 7], 64'h050);
        chk(64'(i_flash.writes - n), 64'h2);
        host(FPL_OP_READ_PEAK, 6'h6, 32'h0);
        chk(rsp, 64'h180);
        host(FPL_OP_READ_PEAK, 6'h7, 32'h0);
        chk(rsp, 64'h050);
        host(FPL_OP_READ_PEAK, 6'h24, 32'h0);
        chk(rsp, 64'h0);
    endtask

    // A fault keeps rail, type and the rail's last voltage sample.
    task automatic test_faults();
        fault_pulse(4'h2, 4'h3);
        host(FPL_OP_READ_FAULT, 6'h0, 32'h0);
        chk(64'({rsp[51:44], rsp[11:0]}), 64'h23120);
        host(FPL_OP_READ_FAULT, 6'h1, 32'h0);
        chk(rsp, 64'h0);
        repeat (10) @(posedge sys_clk);
        chk(64'(i_flash.mem[`FPL_SLOT_FAULT0][51:44]), 64'h23);
    endtask

    // Brownout mode: nothing written until the supply drops, then all of it.
    task automatic test_brownout();
        slow <= 1'b1;
        host(FPL_OP_WRITE_MISC, 6'h0, 32'h1);
        @(posedge sys_clk);
        #1;
        chk(64'(brownout_mode), 64'h1);
        n = i_flash.writes;
        meas_pulse(4'h0, `FPL_QTY_VOLT, 12'h200);
        fault_pulse(4'h0, 4'h1);
        repeat (80) @(posedge sys_clk);
        chk(64'(i_flash.writes - n), 64'h0);
        host(FPL_OP_READ_PEAK, 6'h0, 32'h0);
        chk(rsp, 64'h200);
        meas_pulse(4'h1, `FPL_QTY_TEMP, 12'h0AB);
        host(FPL_OP_READ_PEAK, 6'h5, 32'h0);
        chk(rsp, 64'h0AB);
        @(posedge sys_clk);
        supply_low <= 1'b1;
        repeat (600) @(posedge sys_clk);
        chk(64'(i_flash.writes - n), 64'h30);
        chk(i_flash.mem[`FPL_SLOT_PEAK0], 64'h200);
        chk(i_flash.mem[`FPL_SLOT_PEAK0 + 5], 64'h0AB);
        chk(64'(i_flash.mem[`FPL_SLOT_FAULT0 + 1][51:44]), 64'h01);
        nv <= '{32'h0, 32'h1F4, 1'b1};
        supply_low <= 1'b0;
        do_reset();
        chk(64'(brownout_mode), 64'h1);
        host(FPL_OP_READ_RTC, 6'h0, 32'h0);
        chk(64'(rsp == 64'h1F4 || rsp == 64'h1F5), 64'h1);
        // About thirty cycles after reset the fault time must read about three ticks.
        repeat (30) @(posedge sys_clk);
        fault_pulse(4'h4, 4'h2);
        host(FPL_OP_READ_FAULT, 6'h0, 32'h0);
        chk(64'(rsp[51:44]), 64'h42);
        chk(64'(rsp[43:12] >= 32'h2 && rsp[43:12] <= 32'h4), 64'h1);
        host(FPL_OP_READ_RESETS, 6'h0, 32'h0);
        chk(rsp, 64'h1);
    endtask

    // Main sequence.
    initial begin
        rst         = 1'b1;
        supply_low  = 1'b0;
        slow        = 1'b0;
        meas        = '0;
        fault_in    = '0;
        host_req    = '0;
        nv          = '{32'h5, 32'h64, 1'b0};
        compares    = 0;
        miscompares = 0;
        do_reset();
        test_boot();
        test_rtc();
        test_peaks();
        test_faults();
        test_brownout();
        tally_and_finish();
    end
endmodule
